/* File: sim/iod_decoder_tb_top.sv */
// Testbench for the image opcode decoder and its wrapping atomic unit.
`timescale 1ns/1ns

module iod_decoder_tb_top;
  import iod_pkg::*;
  logic              sys_clk, rst_b, iss_valid, iss_ready, dec_valid_q;
  logic              dec_ready, stall, rmw_valid, rmw_done_q, rmw_write_q;
  logic [6:0]        iss_op, rmw_op;
  logic [3:0]        iss_comp_en;
  logic [31:0]       rmw_old, rmw_operand, rmw_new_q, rmw_ret_q;
  logic [7:0]        taken_q;
  iod_decode_t       dec_q;
  int                fails, comparisons, cur_op;

  iod_decoder i_iod_decoder (.sys_clk(sys_clk), .rst_b(rst_b), .iss_valid(iss_valid),
    .iss_ready(iss_ready), .iss_op(iss_op), .iss_comp_en(iss_comp_en),
    .dec_valid_q(dec_valid_q), .dec_ready(dec_ready), .dec_q(dec_q),
    .rmw_valid(rmw_valid), .rmw_op(rmw_op), .rmw_old(rmw_old),
    .rmw_operand(rmw_operand), .rmw_done_q(rmw_done_q), .rmw_write_q(rmw_write_q),
    .rmw_new_q(rmw_new_q), .rmw_ret_q(rmw_ret_q));
  iod_pipe_model i_iod_pipe_model (.sys_clk(sys_clk), .rst_b(rst_b), .stall(stall),
    .dec_valid_q(dec_valid_q), .dec_ready(dec_ready), .taken_q(taken_q));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The clock runs at 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s op %0d exp %h got %h", n, cur_op, e, g);
    end
  endtask

  function automatic logic [2:0] pop(input logic [3:0] m);
    return 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
  endfunction

  // Level source follows the variant code in the low opcode bits.
  function automatic logic [1:0] lvl(input logic [2:0] v);
    return (v == 3'h4) ? 2'h1 : (v == 3'h5 || v == 3'h6) ? 2'h2 : (v == 3'h7) ? 2'h3 : 2'h0;
  endfunction

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Decode expectations for one opcode
  // ----------------------------------------------------------------
  task automatic chk_op(input int op, input logic [3:0] m);
    logic [6:0] o;
    logic [2:0] v;
    logic       ok, row;
    o = 7'(op);
    v = o[2:0];
    row = (op == 66 || op == 74 || op == 75);
    ok = op == 27 || op == 28 || (op >= 32 && op <= 96 && !(op inside {67, 82, 83, 90, 91}))
         || (op >= 104 && op <= 111);
    cur_op = op;
    cmp("illegal", 32'(!ok), 32'(dec_q.illegal));
    if (!ok) begin
      cmp("cls", 32'(IOD_CLS_NONE), 32'(dec_q.cls));
      cmp("words", 32'h0, 32'(dec_q.ret_words));
    end else if (op < 32) begin
      cmp("cls", 32'((op == 27) ? IOD_CLS_ATOM_INC : IOD_CLS_ATOM_DEC),
          32'(dec_q.cls));
    end else if (op < 64) begin
      cmp("cls", 32'(IOD_CLS_SAMPLE), 32'(dec_q.cls));
      cmp("cmp_off", 32'({o[3], o[4]}), 32'({dec_q.compare, dec_q.offset}));
      cmp("clamp", 32'(v == 1 || v == 3 || v == 6), 32'(dec_q.clamp));
      cmp("deriv", 32'(v == 2 || v == 3), 32'(dec_q.user_deriv));
      cmp("level", 32'(lvl(v)), 32'(dec_q.level));
      cmp("words", 32'(pop(m)), 32'(dec_q.ret_words));
      cmp("mask", 32'(m), 32'(dec_q.comp_en));
    end else if (op < 96) begin
      cmp("cls", 32'(IOD_CLS_GATHER), 32'(dec_q.cls));
      cmp("fp", 32'((op == 75) ? IOD_FP_8X1 : row ? IOD_FP_4X1 : IOD_FP_2X2),
          32'(dec_q.footprint));
      cmp("packed", 32'(op == 74 || op == 75), 32'(dec_q.packed_out));
      cmp("words", 32'((op == 74) ? 1 : (op == 75) ? 2 : 4), 32'(dec_q.ret_words));
      if (!row) begin
        cmp("cmp_off", 32'({o[3], o[4]}), 32'({dec_q.compare, dec_q.offset}));
        cmp("clamp", 32'(v == 1 || v == 6), 32'(dec_q.clamp));
        cmp("level", 32'(lvl(v)), 32'(dec_q.level));
      end
    end else if (op == 96) begin
      cmp("cls", 32'(IOD_CLS_LOD_QUERY), 32'(dec_q.cls));
      cmp("words", 32'h2, 32'(dec_q.ret_words));
    end else begin
      cmp("cls", 32'(IOD_CLS_SAMPLE), 32'(dec_q.cls));
      cmp("quad", 32'h3, 32'({dec_q.quad_lod, dec_q.user_deriv}));
      cmp("cl_c_o", 32'({o[0], o[1], o[2]}),
          32'({dec_q.clamp, dec_q.compare, dec_q.offset}));
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every opcode back to back, with the mask changing each cycle.
  task automatic t_sweep();
    for (int op = 0; op < 128; op++) begin
      iss_valid = 1'b1;
      iss_op = 7'(op);
      iss_comp_en = 4'(op) ^ 4'h5;
      @(posedge sys_clk);
      #1;
      chk_op(op, 4'(op) ^ 4'h5);
    end
    iss_valid = 1'b0;
    $display("sweep done");
  endtask

  // A stalled slot must hold its decode and refuse the next request.
  task automatic t_stall();
    logic [7:0] t0;
    // Let the last sweep slot drain so the first stalled opcode is taken at once.
    @(posedge sys_clk);
    #1;
    t0 = taken_q;
    stall = 1'b1;
    iss_valid = 1'b1;
    iss_op = 7'h40;
    @(posedge sys_clk);
    #1;
    iss_op = 7'h4b;
    repeat (3) begin
      @(posedge sys_clk);
      #1;
      cmp("ready", 32'h0, 32'(iss_ready));
      cmp("fp", 32'(IOD_FP_2X2), 32'(dec_q.footprint));
    end
    stall = 1'b0;
    @(posedge sys_clk);
    #1;
    iss_valid = 1'b0;
    cmp("fp", 32'(IOD_FP_8X1), 32'(dec_q.footprint));
    @(posedge sys_clk);
    #1;
    cmp("valid", 32'h0, 32'(dec_valid_q));
    cmp("taken", 32'(t0 + 8'h02), 32'(taken_q));
    $display("stall done");
  endtask

  // Wrapping atomics back to back, including limits and a non-atomic opcode.
  task automatic t_atomic();
    logic [6:0]  op [9] = '{7'h1b, 7'h1b, 7'h1b, 7'h1b, 7'h1c, 7'h1c, 7'h1c, 7'h1c, 7'h20};
    logic [31:0] od [9] = '{32'h5, 32'h4, 32'hffffffff, 32'h0, 32'h0, 32'h9, 32'h7, 32'h1, 32'h3};
    logic [31:0] pd [9] = '{32'h5, 32'h5, 32'hffffffff, 32'h0, 32'h7, 32'h7, 32'h7, 32'h7, 32'h1};
    logic [31:0] nw [9] = '{32'h0, 32'h5, 32'h0, 32'h0, 32'h7, 32'h7, 32'h6, 32'h0, 32'h3};
    for (int i = 0; i < 9; i++) begin
      rmw_valid = 1'b1;
      rmw_op = op[i];
      rmw_old = od[i];
      rmw_operand = pd[i];
      cur_op = int'(op[i]);
      @(posedge sys_clk);
      #1;
      cmp("done", 32'h1, 32'(rmw_done_q));
      cmp("write", 32'(i < 8), 32'(rmw_write_q));
      cmp("new", nw[i], rmw_new_q);
      cmp("ret", od[i], rmw_ret_q);
    end
    rmw_valid = 1'b0;
    @(posedge sys_clk);
    #1;
    cmp("done", 32'h0, 32'(rmw_done_q));
    $display("atomic done");
  endtask

  // Reset in mid-run must empty a held slot.
  task automatic t_reset();
    stall = 1'b1;
    iss_valid = 1'b1;
    iss_op = 7'h60;
    @(posedge sys_clk);
    #1;
    iss_valid = 1'b0;
    rst_b = 1'b0;
    #1;
    cmp("valid", 32'h0, 32'(dec_valid_q));
    cmp("ready", 32'h1, 32'(iss_ready));
    @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    stall = 1'b0;
    // The first request after release must be taken and decoded normally.
    iss_valid = 1'b1;
    iss_op = 7'h40;
    @(posedge sys_clk);
    #1;
    iss_valid = 1'b0;
    cmp("valid", 32'h1, 32'(dec_valid_q));
    chk_op(64, iss_comp_en);
    $display("reset done");
  endtask

  // Watchdog cuts a hang short.
  initial begin
    #200000;
    fails++;
    complete_run();
  end

  initial begin
    {rst_b, stall, iss_valid, rmw_valid} = 4'h0;
    {iss_op, rmw_op, iss_comp_en} = 18'h0;
    {rmw_old, rmw_operand} = 64'h0;
    repeat (20) @(posedge sys_clk);
    #1;
    cmp("ready", 32'h1, 32'(iss_ready));
    rst_b = 1'b1;
    t_sweep();
    t_stall();
    t_atomic();
    t_reset();
    complete_run();
  end
endmodule

/* File: sim/iod_pipe_model.sv */
// Texture pipeline stand-in that takes decodes and can stall on command.
`timescale 1ns/1ns

module iod_pipe_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        stall,
  input  wire logic        dec_valid_q,
  output logic             dec_ready,
  output logic [7:0]       taken_q
);
  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  // Ready follows the stall request at once, so a stall holds the slot.
  assign dec_ready = !stall;

  // Counting taken slots lets the bench see a slot was consumed only once.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      taken_q <= 8'h00;
    end else if (dec_valid_q && dec_ready) begin
      taken_q <= taken_q + 8'h01;
    end
  end
endmodule

/* File: verilog/iod_decoder.sv */
// Image instruction opcode decoder with wrapping atomic update unit.
`timescale 1ns/1ns

module iod_decoder #(
  parameter int OPCODE_W = iod_pkg::OP_W,
  parameter int WORD_W   = iod_pkg::DATA_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic                  iss_valid,
  output logic                       iss_ready,
  input  wire logic [OPCODE_W-1:0]   iss_op,
  input  wire logic [iod_pkg::COMP_W-1:0] iss_comp_en,
  output logic                       dec_valid_q,
  input  wire logic                  dec_ready,
  output iod_pkg::iod_decode_t       dec_q,
  input  wire logic                  rmw_valid,
  input  wire logic [OPCODE_W-1:0]   rmw_op,
  input  wire logic [WORD_W-1:0]     rmw_old,
  input  wire logic [WORD_W-1:0]     rmw_operand,
  output logic                       rmw_done_q,
  output logic                       rmw_write_q,
  output logic [WORD_W-1:0]          rmw_new_q,
  output logic [WORD_W-1:0]          rmw_ret_q
);
  import iod_pkg::*;

  // ----------------------------------------------------------------
  // Variant and opcode decode
  // ----------------------------------------------------------------

  // Clamp, derivative and level source shared by sample and collect groups.
  function automatic iod_decode_t iod_apply_variant(iod_decode_t d, logic [2:0] v);
    d.clamp      = (v == VAR_CL) || (v == VAR_D_CL) || (v == VAR_B_CL);
    d.user_deriv = (v == VAR_D) || (v == VAR_D_CL);
    case (v)
      VAR_L:             d.level = IOD_LVL_EXPLICIT;
      VAR_B, VAR_B_CL:   d.level = IOD_LVL_BIAS;
      VAR_LZ:            d.level = IOD_LVL_ZERO;
      default:           d.level = IOD_LVL_AUTO;
    endcase
    return d;
  endfunction

  // Number of set bits in the component enable mask.
  function automatic logic [2:0] iod_count(logic [COMP_W-1:0] m);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < COMP_W; i++) begin
      n = n + {2'h0, m[i]};
    end
    return n;
  endfunction

  // Pure combinational decode of one opcode.
  function automatic iod_decode_t iod_decode(logic [OPCODE_W-1:0] op,
                                             logic [COMP_W-1:0] cen);
    iod_decode_t d;
    logic [2:0]  v;
    d         = '0;
    d.cls     = IOD_CLS_NONE;
    d.illegal = 1'b1;
    d.comp_en = cen;
    v         = op[OPB_VAR_MSB:0];
    if (op == OP_ATOM_INC || op == OP_ATOM_DEC) begin
      d.illegal   = 1'b0;
      d.cls       = (op == OP_ATOM_INC) ? IOD_CLS_ATOM_INC : IOD_CLS_ATOM_DEC;
      d.ret_words = WORDS_ATOMIC;
    end else if (op >= OP_SAMPLE_FIRST && op <= OP_SAMPLE_LAST) begin
      // Sample groups follow a regular bit layout, so one path covers all 32.
      d           = iod_apply_variant(d, v);
      d.illegal   = 1'b0;
      d.cls       = IOD_CLS_SAMPLE;
      d.compare   = op[OPB_COMPARE];
      d.offset    = op[OPB_OFFSET];
      d.ret_words = iod_count(cen);
    end else if (op >= OP_GATHER_FIRST && op <= OP_GATHER_LAST) begin
      d           = iod_apply_variant(d, v);
      d.user_deriv = 1'b0;
      d.clamp     = (v == VAR_CL) || (v == VAR_B_CL);
      d.cls       = IOD_CLS_GATHER;
      d.compare   = op[OPB_COMPARE];
      d.offset    = op[OPB_OFFSET];
      d.footprint = IOD_FP_2X2;
      d.ret_words = WORDS_GATHER;
      d.illegal   = 1'b0;
      // Derivative slots are reused by the row collects in the non-offset half.
      if (v == VAR_D || v == VAR_D_CL) begin
        d.compare = 1'b0;
        if (op[OPB_OFFSET]) begin
          d.illegal = 1'b1;
        end else if (!op[OPB_COMPARE]) begin
          d.footprint = IOD_FP_4X1;
          d.illegal   = (v == VAR_D_CL);
        end else if (v == VAR_D) begin
          d.footprint  = IOD_FP_4X1;
          d.packed_out = 1'b1;
          d.ret_words  = WORDS_ROW4P;
        end else begin
          d.footprint  = IOD_FP_8X1;
          d.packed_out = 1'b1;
          d.ret_words  = WORDS_ROW8P;
        end
      end
    end else if (op == OP_LOD_QUERY) begin
      d.illegal   = 1'b0;
      d.cls       = IOD_CLS_LOD_QUERY;
      d.ret_words = WORDS_LOD;
    end else if (op >= OP_QUAD_FIRST && op <= OP_QUAD_LAST) begin
      d.illegal    = 1'b0;
      d.cls        = IOD_CLS_SAMPLE;
      d.user_deriv = 1'b1;
      d.quad_lod   = 1'b1;
      d.clamp      = op[QB_CLAMP];
      d.compare    = op[QB_COMPARE];
      d.offset     = op[QB_OFFSET];
      d.ret_words  = iod_count(cen);
    end
    if (d.illegal) begin
      // An illegal opcode carries no operation so nothing downstream acts on it.
      d.cls       = IOD_CLS_NONE;
      d.footprint = IOD_FP_NONE;
      d.ret_words = 3'h0;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Issue stage
  // ----------------------------------------------------------------

  // One register stage; a new opcode is taken while the slot is empty or draining.
  assign iss_ready = !dec_valid_q || dec_ready;

  // Valid flag of the decode slot.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_valid_q <= 1'b0;
    end else if (iss_ready) begin
      dec_valid_q <= iss_valid;
    end
  end

  // Decoded fields, held while the consumer stalls.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_q <= '0;
    end else if (iss_ready && iss_valid) begin
      dec_q <= iod_decode(iss_op, iss_comp_en);
    end
  end

  // ----------------------------------------------------------------
  // Wrapping atomic update
  // ----------------------------------------------------------------

  // The memory side supplies the old word; the new word and return come one cycle later.
  // Compares are unsigned, so the counter wraps at the operand, not at the word size.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rmw_done_q  <= 1'b0;
      rmw_write_q <= 1'b0;
      rmw_new_q   <= '0;
      rmw_ret_q   <= '0;
    end else begin
      rmw_done_q  <= rmw_valid;
      rmw_write_q <= rmw_valid && (rmw_op == OP_ATOM_INC || rmw_op == OP_ATOM_DEC);
      if (rmw_valid) begin
        rmw_ret_q <= rmw_old;
        if (rmw_op == OP_ATOM_INC) begin
          rmw_new_q <= (rmw_old >= rmw_operand) ? '0 : rmw_old + 1'b1;
        end else if (rmw_op == OP_ATOM_DEC) begin
          rmw_new_q <= (rmw_old == '0 || rmw_old > rmw_operand) ?
                       rmw_operand : rmw_old - 1'b1;
        end else begin
          rmw_new_q <= rmw_old;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic accept;
  assign accept = iss_valid && iss_ready;

  chk_inc_wrap_value: assert property (
    rmw_valid && rmw_op == OP_ATOM_INC |=> rmw_write_q && rmw_ret_q == $past(rmw_old) &&
      rmw_new_q == (($past(rmw_old) >= $past(rmw_operand)) ? '0 : $past(rmw_old) + 1'b1))
    else $error("wrapping increment result wrong");

  chk_dec_wrap_value: assert property (
    rmw_valid && rmw_op == OP_ATOM_DEC && rmw_old == '0 |=> rmw_new_q == $past(rmw_operand)
      && rmw_ret_q == '0)
    else $error("decrement from zero must load operand");

  chk_sample_variant: assert property (
    accept && iss_op == OP_SAMPLE_FIRST + 7'h3 |=> dec_q.cls == IOD_CLS_SAMPLE &&
      dec_q.clamp && dec_q.user_deriv && !dec_q.compare && !dec_q.offset)
    else $error("derivative clamp sample misdecoded");

  chk_compare_level: assert property (
    accept && iss_op == OP_SAMPLE_FIRST + 7'hf |=> dec_q.compare &&
      dec_q.level == IOD_LVL_ZERO && !dec_q.offset)
    else $error("compare level zero sample misdecoded");

  chk_offset_forms: assert property (
    accept && iss_op >= OP_SAMPLE_FIRST + 7'h10 && iss_op <= OP_SAMPLE_LAST |=>
      dec_q.offset && dec_q.compare == $past(iss_op[OPB_COMPARE]))
    else $error("offset sample misdecoded");

  chk_row_collects: assert property (
    accept && iss_op == OP_GATHER_FIRST + 7'hb |=> dec_q.footprint == IOD_FP_8X1 &&
      dec_q.packed_out && dec_q.ret_words == WORDS_ROW8P && !dec_q.compare)
    else $error("eight texel packed collect misdecoded");

  chk_quad_collect: assert property (
    accept && iss_op == OP_GATHER_FIRST + 7'h9 |=> dec_q.footprint == IOD_FP_2X2 &&
      dec_q.compare && dec_q.clamp && dec_q.ret_words == WORDS_GATHER)
    else $error("compare clamp collect misdecoded");

  chk_lod_words: assert property (
    accept && iss_op == OP_LOD_QUERY |=> dec_q.cls == IOD_CLS_LOD_QUERY &&
      dec_q.ret_words == WORDS_LOD && dec_q.footprint == IOD_FP_NONE)
    else $error("level query misdecoded");

  chk_quad_level: assert property (
    accept && iss_op >= OP_QUAD_FIRST && iss_op <= OP_QUAD_LAST |=> dec_q.quad_lod &&
      dec_q.user_deriv && dec_q.offset == $past(iss_op[QB_OFFSET]))
    else $error("quad level sample misdecoded");

  chk_hole_illegal: assert property (
    accept && (iss_op == OP_GATHER_FIRST + 7'h12 || iss_op == OP_GATHER_FIRST + 7'h1b ||
      iss_op == OP_LOD_QUERY + 7'h1) |=> dec_q.illegal && dec_q.cls == IOD_CLS_NONE)
    else $error("absent opcode not flagged");

  chk_mask_follow: assert property (
    accept |=> dec_valid_q && dec_q.comp_en == $past(iss_comp_en))
    else $error("component mask not carried");

  chk_stall_hold: assert property (
    dec_valid_q && !dec_ready |=> dec_valid_q && $stable(dec_q))
    else $error("decode slot changed while stalled");

  chk_row_four: assert property (
    accept && iss_op == OP_GATHER_FIRST + 7'h2 |=> dec_q.footprint == IOD_FP_4X1 &&
      !dec_q.packed_out && dec_q.ret_words == WORDS_GATHER && !dec_q.illegal)
    else $error("row of four collect misdecoded");

  chk_row_packed: assert property (
    accept && iss_op == OP_GATHER_FIRST + 7'ha |=> dec_q.footprint == IOD_FP_4X1 &&
      dec_q.packed_out && dec_q.ret_words == WORDS_ROW4P && !dec_q.compare)
    else $error("packed row of four collect misdecoded");

  chk_offset_collect: assert property (
    accept && iss_op == OP_GATHER_FIRST + 7'h1c |=> dec_q.footprint == IOD_FP_2X2 &&
      dec_q.offset && dec_q.compare && dec_q.level == IOD_LVL_EXPLICIT)
    else $error("offset compare level collect misdecoded");

  chk_atomic_strobe: assert property (
    rmw_valid |=> rmw_done_q && rmw_ret_q == $past(rmw_old) &&
      rmw_write_q == ($past(rmw_op) == OP_ATOM_INC || $past(rmw_op) == OP_ATOM_DEC))
    else $error("atomic strobe or return wrong");

  chk_dec_step: assert property (
    rmw_valid && rmw_op == OP_ATOM_DEC && rmw_old != '0 && rmw_old <= rmw_operand |=>
      rmw_new_q == $past(rmw_old) - 1'b1)
    else $error("in range decrement must step down");

  chk_dec_above: assert property (
    rmw_valid && rmw_op == OP_ATOM_DEC && rmw_old > rmw_operand |=>
      rmw_new_q == $past(rmw_operand))
    else $error("decrement above operand must load operand");

  chk_low_illegal: assert property (
    accept && iss_op < OP_ATOM_INC |=> dec_q.illegal && dec_q.cls == IOD_CLS_NONE &&
      dec_q.ret_words == '0)
    else $error("opcode below the atomics not flagged");

  cov_atomic_wrap: cover property (rmw_valid && rmw_op == OP_ATOM_INC &&
    rmw_old >= rmw_operand ##1 rmw_new_q == '0);
  cov_illegal_seen: cover property (dec_valid_q && dec_q.illegal);
  cov_packed_row: cover property (dec_valid_q && dec_q.packed_out);
  cov_stall_then_go: cover property (dec_valid_q && !dec_ready ##1 dec_ready);

endmodule

/* File: verilog/iod_pkg.sv */
// Shared constants and types for the image opcode decoder.
package iod_pkg;

  // ----------------------------------------------------------------
  // Opcode field and opcode values
  // ----------------------------------------------------------------
  localparam int OP_W = 7;
  localparam int DATA_W = 32;
  localparam int COMP_W = 4;
  localparam logic [OP_W-1:0] OP_ATOM_INC     = 7'h1b;
  localparam logic [OP_W-1:0] OP_ATOM_DEC     = 7'h1c;
  localparam logic [OP_W-1:0] OP_SAMPLE_FIRST = 7'h20;
  localparam logic [OP_W-1:0] OP_SAMPLE_LAST  = 7'h3f;
  localparam logic [OP_W-1:0] OP_GATHER_FIRST = 7'h40;
  localparam logic [OP_W-1:0] OP_GATHER_LAST  = 7'h5f;
  localparam logic [OP_W-1:0] OP_LOD_QUERY    = 7'h60;
  localparam logic [OP_W-1:0] OP_QUAD_FIRST   = 7'h68;
  localparam logic [OP_W-1:0] OP_QUAD_LAST    = 7'h6f;

  // ----------------------------------------------------------------
  // Bit positions inside the sample and gather opcode groups
  // ----------------------------------------------------------------
  localparam int OPB_OFFSET  = 4;
  localparam int OPB_COMPARE = 3;
  localparam int OPB_VAR_MSB = 2;
  localparam int QB_CLAMP    = 0;
  localparam int QB_COMPARE  = 1;
  localparam int QB_OFFSET   = 2;

  // Variant codes in the low opcode bits.
  localparam logic [2:0] VAR_PLAIN = 3'h0;
  localparam logic [2:0] VAR_CL    = 3'h1;
  localparam logic [2:0] VAR_D     = 3'h2;
  localparam logic [2:0] VAR_D_CL  = 3'h3;
  localparam logic [2:0] VAR_L     = 3'h4;
  localparam logic [2:0] VAR_B     = 3'h5;
  localparam logic [2:0] VAR_B_CL  = 3'h6;
  localparam logic [2:0] VAR_LZ    = 3'h7;

  // Returned word counts.
  localparam logic [2:0] WORDS_ATOMIC = 3'h1;
  localparam logic [2:0] WORDS_GATHER = 3'h4;
  localparam logic [2:0] WORDS_ROW4P  = 3'h1;
  localparam logic [2:0] WORDS_ROW8P  = 3'h2;
  localparam logic [2:0] WORDS_LOD    = 3'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOD_CLS_NONE, IOD_CLS_ATOM_INC, IOD_CLS_ATOM_DEC,
    IOD_CLS_SAMPLE, IOD_CLS_GATHER, IOD_CLS_LOD_QUERY
  } iod_class_t;

  typedef enum logic [1:0] {
    IOD_LVL_AUTO, IOD_LVL_EXPLICIT, IOD_LVL_BIAS, IOD_LVL_ZERO
  } iod_level_t;

  typedef enum logic [1:0] {
    IOD_FP_NONE, IOD_FP_2X2, IOD_FP_4X1, IOD_FP_8X1
  } iod_footprint_t;

  typedef struct packed {
    logic              illegal;
    iod_class_t        cls;
    logic              clamp;
    logic              user_deriv;
    logic              quad_lod;
    logic              compare;
    logic              offset;
    logic              packed_out;
    iod_level_t        level;
    iod_footprint_t    footprint;
    logic [2:0]        ret_words;
    logic [COMP_W-1:0] comp_en;
  } iod_decode_t;

endpackage
